// file: pomx_pkg.sv
// constants shared by the synthesizer output mux register group
package pomx_pkg;

    // ==================== bus geometry
    localparam int ADDR_W = 6;
    localparam int DATA_W = 24;

    // ==================== register offsets
    localparam logic [ADDR_W-1:0] OFS_EXACT_FREQ_CHANNELS = 6'h0C;
    localparam logic [ADDR_W-1:0] OFS_GENERAL_OUTPUT_CONTROL = 6'h0F;
    localparam logic [ADDR_W-1:0] OFS_RESERVED_READBACK_A = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_RESERVED_READBACK_B = 6'h11;
    localparam logic [ADDR_W-1:0] OFS_OUTPUT_LOCK_STATUS = 6'h12;
    localparam logic [ADDR_W-1:0] OFS_SELF_TEST_RESULT = 6'h13;

    // ==================== channel count field
    localparam int CHAN_W = 14;
    localparam logic [CHAN_W-1:0] CHAN_RESET = 14'h0000;
    localparam logic [CHAN_W-1:0] CHAN_MIN_EXACT = 14'h0002;

    // ==================== output control fields
    localparam int SEL_W = 5;
    localparam int SEL_LSB = 0;
    localparam int TEST_DATA_BIT = 5;
    localparam int HOLD_MUX_BIT = 6;
    localparam int KEEP_DRIVER_BIT = 7;
    localparam int PULLUP_OFF_BIT = 8;
    localparam int PULLDOWN_OFF_BIT = 9;
    localparam logic [SEL_W-1:0] SEL_RESET = 5'h01;

    // ==================== output select codes
    localparam logic [SEL_W-1:0] SEL_TEST_DATA = 5'h00;
    localparam logic [SEL_W-1:0] SEL_LOCK_DETECT = 5'h01;
    localparam logic [SEL_W-1:0] SEL_LOCK_TRIGGER = 5'h02;
    localparam logic [SEL_W-1:0] SEL_LOCK_WINDOW = 5'h03;
    localparam logic [SEL_W-1:0] SEL_SLIP_PULL_UP = 5'h05;
    localparam logic [SEL_W-1:0] SEL_SLIP_PULL_DOWN = 5'h06;
    localparam logic [SEL_W-1:0] SEL_REF_BUFFER = 5'h08;
    localparam logic [SEL_W-1:0] SEL_VCO_DIVIDER = 5'h0A;
    localparam logic [SEL_W-1:0] SEL_MOD_CLOCK = 5'h0B;
    localparam logic [SEL_W-1:0] SEL_AUX_CLOCK = 5'h0C;
    localparam logic [SEL_W-1:0] SEL_PD_DOWN = 5'h0F;
    localparam logic [SEL_W-1:0] SEL_PD_UP = 5'h11;
    localparam logic [SEL_W-1:0] SEL_LATCH_ENABLE = 5'h17;
    localparam logic [SEL_W-1:0] SEL_DIV_SYNC_RESET = 5'h18;
    localparam logic [SEL_W-1:0] SEL_SEED_LOAD = 5'h19;
    localparam logic [SEL_W-1:0] SEL_OUT_BUF_ENABLE = 5'h1E;
    localparam logic [SEL_W-1:0] SEL_SOFT_RESET = 5'h1F;
    // codes that carry a source; 7, 9 and 26..29 read as low
    localparam logic [31:0] SEL_USED_MASK = 32'hC3FFFD7E;

    // ==================== status and self-test fields
    localparam int STAT_GPO_BIT = 0;
    localparam int STAT_LOCK_BIT = 1;
    localparam int SIG_W = 16;
    localparam int BUSY_BIT = 16;

endpackage

// file: pomx_sync.sv
// three-stage synchroniser with agreement filter for signals from other domains
`timescale 1ns/1ps

module pomx_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // data
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    // ==================== stages
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] out;
    } pomx_sync_s;

    pomx_sync_s st_q;
    pomx_sync_s st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = i_async;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // s1 is never looked at; a bit moves only when stages two and three agree
        for (int i = 0; i < W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.out[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_sync = st_q.out;

endmodule // pomx_sync

// file: pomx_regs.sv
// output mux, channel count and readback registers of the fractional-N synthesizer
//
// Function
// - 14-bit read-write channel count field, reset to zero.
// - counts 0 and 1 disable exact frequency; 2 to 16383 enable it.
// - 5-bit output select, reset 1, chooses signal driven on data out.
// - codes 1, 2, 3 route lock detect, lock trigger, lock window.
// - codes 5, 6 route slip-prevention pulls; 15, 17 phase detector down, up.
// - codes 8, 10, 11, 12 route reference, divider, modulator clock, aux clock.
// - codes 23-25 latch, divider reset, seed load; 30, 31 buffer enable, soft reset.
// - select zero drives the test-data bit 5, reset zero.
// - bit 6 set stops automatic sharing of data out with the general output.
// - bit 7 set keeps serial interface from disabling data out driver.
// - status register shows output value bit 0, lock detect bit 1.
// - 16-bit read-only self-test signature, zero after reset.
// - read-only self-test busy flag at bit 16, zero after reset.
// - two reserved read-only registers read zero; writes ignored.
`timescale 1ns/1ps

module pomx_regs
    import pomx_pkg::*;
#(
    parameter int SRC_W = 32
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // register port from the serial interface
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [pomx_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic [pomx_pkg::DATA_W-1:0] i_reg_wdata,
    output logic [pomx_pkg::DATA_W-1:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // serial interface state for the data out pin
    input wire logic i_spi_read_active,
    input wire logic i_spi_read_data,
    input wire logic i_spi_driver_off,
    // internal synthesizer signals; the source vector is indexed by select code, lock detect is separate
    input wire logic [SRC_W-1:0] i_gpo_src,
    input wire logic i_lock_detect,
    // self-test engine
    input wire logic [pomx_pkg::SIG_W-1:0] i_self_test_signature,
    input wire logic i_self_test_running,
    // data out pin driver
    output logic o_sdo_out,
    output logic o_sdo_oe,
    output logic o_sdo_pullup_on,
    output logic o_sdo_pulldown_on,
    // synthesizer control
    output logic [pomx_pkg::CHAN_W-1:0] o_channel_count_per_compare,
    output logic o_exact_freq_en
);

    import pomx_pkg::*;

    // ==================== reset release
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ==================== crossing of foreign-domain inputs
    localparam int XW = SRC_W + 1 + 1 + SIG_W;

    logic [XW-1:0] x_raw;
    logic [XW-1:0] x_sync;
    logic [SRC_W-1:0] src_s;
    logic lock_s;
    logic busy_s;
    logic [SIG_W-1:0] sig_s;

    assign x_raw = {i_gpo_src, i_lock_detect, i_self_test_running, i_self_test_signature};

    pomx_sync #(
        .W(XW)
    ) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(rst_n),
        .i_async(x_raw),
        .o_sync(x_sync)
    );

    assign {src_s, lock_s, busy_s, sig_s} = x_sync;

    // ==================== state
    typedef struct packed {
        logic [CHAN_W-1:0] chan;
        logic [SEL_W-1:0] sel;
        logic test_data;
        logic hold_data_out_mux;
        logic keep_driver;
        logic pullup_half_off;
        logic pulldown_half_off;
        logic exact_en;
        logic gpo_val;
        logic lock_val;
        logic [SIG_W-1:0] self_test_signature;
        logic self_test_running;
        logic sdo_out;
        logic sdo_oe;
        logic sdo_pu;
        logic sdo_pd;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
    } pomx_regs_s;

    pomx_regs_s st_q;
    pomx_regs_s st_d;

    // ==================== next state
    always_comb begin
        logic gpo_next;
        logic out_next;
        logic oe_next;
        gpo_next = 1'b0;
        out_next = 1'b0;
        oe_next = 1'b0;
        st_d = st_q;

        // ---- register writes
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                OFS_EXACT_FREQ_CHANNELS: begin
                    st_d.chan = i_reg_wdata[CHAN_W-1:0];
                end
                OFS_GENERAL_OUTPUT_CONTROL: begin
                    st_d.sel = i_reg_wdata[SEL_LSB +: SEL_W];
                    st_d.test_data = i_reg_wdata[TEST_DATA_BIT];
                    st_d.hold_data_out_mux = i_reg_wdata[HOLD_MUX_BIT];
                    st_d.keep_driver = i_reg_wdata[KEEP_DRIVER_BIT];
                    st_d.pullup_half_off = i_reg_wdata[PULLUP_OFF_BIT];
                    st_d.pulldown_half_off = i_reg_wdata[PULLDOWN_OFF_BIT];
                end
                default: begin
                end
            endcase
        end

        // exact mode needs count two or more
        st_d.exact_en = (st_q.chan >= CHAN_MIN_EXACT);

        // ---- output select
        // test data at code zero, otherwise the source for the code
        if (st_q.sel == SEL_TEST_DATA) begin
            gpo_next = st_q.test_data;
        end else begin
            gpo_next = src_s[st_q.sel] & SEL_USED_MASK[st_q.sel];
        end
        st_d.gpo_val = gpo_next;

        // readback owns the line while active; otherwise general output shares it
        // sharing blocked by hold bit
        if (i_spi_read_active || st_q.hold_data_out_mux) begin
            out_next = i_spi_read_data;
        end else begin
            out_next = st_q.gpo_val;
        end
        // driver kept on by bit 7
        oe_next = st_q.keep_driver || !i_spi_driver_off;
        st_d.sdo_out = out_next;
        st_d.sdo_oe = oe_next;
        st_d.sdo_pu = oe_next && out_next && !st_q.pullup_half_off;
        st_d.sdo_pd = oe_next && !out_next && !st_q.pulldown_half_off;

        // ---- status capture
        // output and lock state
        st_d.lock_val = lock_s;
        st_d.self_test_running = busy_s;
        // signature is only taken while the engine is idle, so the word is stable
        if (!busy_s) begin
            st_d.self_test_signature = sig_s;
        end

        // ---- register reads
        st_d.rvalid = i_reg_rd;
        if (i_reg_rd) begin
            st_d.rdata = '0;
            unique case (i_reg_addr)
                OFS_EXACT_FREQ_CHANNELS: begin
                    st_d.rdata[CHAN_W-1:0] = st_q.chan;
                end
                OFS_GENERAL_OUTPUT_CONTROL: begin
                    st_d.rdata[SEL_LSB +: SEL_W] = st_q.sel;
                    st_d.rdata[TEST_DATA_BIT] = st_q.test_data;
                    st_d.rdata[HOLD_MUX_BIT] = st_q.hold_data_out_mux;
                    st_d.rdata[KEEP_DRIVER_BIT] = st_q.keep_driver;
                    st_d.rdata[PULLUP_OFF_BIT] = st_q.pullup_half_off;
                    st_d.rdata[PULLDOWN_OFF_BIT] = st_q.pulldown_half_off;
                end
                OFS_OUTPUT_LOCK_STATUS: begin
                    st_d.rdata[STAT_GPO_BIT] = st_q.gpo_val;
                    st_d.rdata[STAT_LOCK_BIT] = st_q.lock_val;
                end
                OFS_SELF_TEST_RESULT: begin
                    st_d.rdata[SIG_W-1:0] = st_q.self_test_signature;
                    st_d.rdata[BUSY_BIT] = st_q.self_test_running;
                end
                default: begin
                end
            endcase
        end
    end

    // ==================== registers
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.sel <= SEL_RESET;
            st_q.chan <= CHAN_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // ==================== outputs
    assign o_reg_rdata = st_q.rdata;
    assign o_reg_rvalid = st_q.rvalid;
    assign o_sdo_out = st_q.sdo_out;
    assign o_sdo_oe = st_q.sdo_oe;
    assign o_sdo_pullup_on = st_q.sdo_pu;
    assign o_sdo_pulldown_on = st_q.sdo_pd;
    assign o_channel_count_per_compare = st_q.chan;
    assign o_exact_freq_en = st_q.exact_en;

endmodule // pomx_regs

// file: pomx_regs_chk_assertions.sv
// port assertions for the output mux register group
`timescale 1ns/1ps

module pomx_regs_chk (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [pomx_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic [pomx_pkg::DATA_W-1:0] i_reg_wdata,
    input wire logic [pomx_pkg::DATA_W-1:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    // data out pin
    input wire logic i_spi_read_active,
    input wire logic i_spi_read_data,
    input wire logic i_spi_driver_off,
    input wire logic o_sdo_out,
    input wire logic o_sdo_oe,
    input wire logic o_sdo_pullup_on,
    input wire logic o_sdo_pulldown_on,
    // synthesizer control
    input wire logic [pomx_pkg::CHAN_W-1:0] o_channel_count_per_compare,
    input wire logic o_exact_freq_en
);
    import pomx_pkg::*;
    // ==========================================
    // helper
    // design lags reset release by two flops
    logic [1:0] up_q;
    logic ready;
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    end
    assign ready = (up_q == 2'h3);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    // ==========================================
    // assertions
    a_rvalid_pulse: assert property (ready |-> o_reg_rvalid == $past(i_reg_rd))
        else $error("read valid not one cycle after read");
    a_rdata_hold: assert property (ready && !i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data moved without a read");
    a_count_write: assert property (ready && i_reg_wr && i_reg_addr == OFS_EXACT_FREQ_CHANNELS
        |=> {10'h000, o_channel_count_per_compare} == ($past(i_reg_wdata) & 24'h003FFF))
        else $error("channel count not written");
    a_exact_enable: assert property (ready |->
        o_exact_freq_en == ($past(o_channel_count_per_compare) >= CHAN_MIN_EXACT))
        else $error("exact enable wrong for count");
    a_reserved_zero: assert property (ready && i_reg_rd &&
        (i_reg_addr == OFS_RESERVED_READBACK_A || i_reg_addr == OFS_RESERVED_READBACK_B)
        |=> o_reg_rdata == 24'h000000) else $error("reserved read not zero");
    a_readback_out: assert property (ready && i_spi_read_active
        |=> o_sdo_out == $past(i_spi_read_data)) else $error("readback bit not on data out");
    a_driver_kept: assert property (ready && !i_spi_driver_off |=> o_sdo_oe)
        else $error("driver off without request");
    a_pullup_half: assert property (o_sdo_pullup_on |-> o_sdo_oe && o_sdo_out)
        else $error("pull-up on while not driving high");
    a_pulldown_half: assert property (o_sdo_pulldown_on |-> o_sdo_oe && !o_sdo_out)
        else $error("pull-down on while not driving low");
    c_count: cover property (i_reg_wr && i_reg_addr == OFS_EXACT_FREQ_CHANNELS);
    c_readback: cover property (i_spi_read_active ##1 o_sdo_out);
    c_exact: cover property ($rose(o_exact_freq_en));
endmodule // pomx_regs_chk

bind pomx_regs pomx_regs_chk u_chk (.i_clk_sys, .i_resetn, .i_reg_wr, .i_reg_rd, .i_reg_addr,
    .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .i_spi_read_active, .i_spi_read_data,
    .i_spi_driver_off, .o_sdo_out, .o_sdo_oe, .o_sdo_pullup_on, .o_sdo_pulldown_on,
    .o_channel_count_per_compare, .o_exact_freq_en);

// file: pomx_host.sv
// serial host model issuing register writes and reads
`timescale 1ns/1ps

module pomx_host (
    // clock
    input wire logic i_clk_sys,
    // register port towards the device
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [pomx_pkg::ADDR_W-1:0] o_reg_addr,
    output logic [pomx_pkg::DATA_W-1:0] o_reg_wdata,
    input wire logic [pomx_pkg::DATA_W-1:0] i_reg_rdata,
    input wire logic i_reg_rvalid
);
    import pomx_pkg::*;
    bit exact_mode = 1'b1;
    int gap = 0;
    initial begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 6'h00;
        o_reg_wdata = 24'h000000;
    end
    // released lines get the inverse, never the last value
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        repeat (gap + 1) @(posedge i_clk_sys);
        o_reg_wr <= 1'b1;
        o_reg_addr <= a;
        o_reg_wdata <= (a == OFS_EXACT_FREQ_CHANNELS && !exact_mode) ? 24'h000000 : d;
        @(posedge i_clk_sys);
        o_reg_wr <= 1'b0;
        o_reg_addr <= ~a;
        o_reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        int n;
        repeat (gap + 1) @(posedge i_clk_sys);
        o_reg_rd <= 1'b1;
        o_reg_addr <= a;
        @(posedge i_clk_sys);
        o_reg_rd <= 1'b0;
        o_reg_addr <= ~a;
        d = 'x;
        for (n = 0; n < 8; n++) begin
            @(posedge i_clk_sys);
            if (i_reg_rvalid === 1'b1) begin
                d = i_reg_rdata;
                break;
            end
        end
    endtask
endmodule // pomx_host

// file: pomx_regs_tb_top.sv
// self-checking bench for the output mux register group
`timescale 1ns/1ps

module pomx_regs_tb_top;
    import pomx_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_resetn = 1'b0;
    logic i_reg_wr, i_reg_rd, o_reg_rvalid;
    logic [ADDR_W-1:0] i_reg_addr;
    logic [DATA_W-1:0] i_reg_wdata, o_reg_rdata, rv, w;
    logic i_spi_read_active = 0, i_spi_read_data = 0, i_spi_driver_off = 0, i_lock_detect = 0;
    logic [31:0] i_gpo_src = 0;
    logic [SIG_W-1:0] i_self_test_signature = 0;
    logic i_self_test_running = 0, o_sdo_out, o_sdo_oe, o_sdo_pullup_on, o_sdo_pulldown_on;
    logic [CHAN_W-1:0] o_channel_count_per_compare;
    logic o_exact_freq_en, g, oe;
    logic [ADDR_W-1:0] addrs [8] = '{6'h0C, 6'h0F, 6'h10, 6'h11, 6'h12, 6'h13, 6'h00, 6'h3F};
    logic [DATA_W-1:0] cvals [6] = '{24'h0, 24'h1, 24'h2, 24'h3FFF, 24'hFFFFFF, 24'h0};
    int errors = 0, total_checks = 0, cycles = 0;
    always #4 i_clk_sys = ~i_clk_sys;
    pomx_regs u_dut (.i_clk_sys, .i_resetn, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
        .o_reg_rdata, .o_reg_rvalid, .i_spi_read_active, .i_spi_read_data, .i_spi_driver_off,
        .i_gpo_src, .i_lock_detect, .i_self_test_signature, .i_self_test_running, .o_sdo_out,
        .o_sdo_oe, .o_sdo_pullup_on, .o_sdo_pulldown_on, .o_channel_count_per_compare,
        .o_exact_freq_en);
    pomx_host u_host (.i_clk_sys, .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd), .o_reg_addr(i_reg_addr),
        .o_reg_wdata(i_reg_wdata), .i_reg_rdata(o_reg_rdata), .i_reg_rvalid(o_reg_rvalid));
    // ==========================================
    // expectations and reporting
    function automatic logic exp_gpo(logic [4:0] c, logic [31:0] s, logic t);
        return (c == 5'h00) ? t : (SEL_USED_MASK[c] ? s[c] : 1'b0);
    endfunction
    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // synchronisers need about six edges
    task automatic settle();
        repeat (10) @(posedge i_clk_sys);
    endtask
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            report_and_stop();
        end
    end
    // ==========================================
    // scenarios
    initial begin
        rv = 24'($urandom(84));
        repeat (6) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        foreach (addrs[i]) begin
            u_host.rd(addrs[i], rv);
            chk("reset value", rv, (i == 1) ? 24'h000001 : 24'h000000);
            if (i > 1) begin
                u_host.wr(addrs[i], 24'hFFFFFF);
                u_host.rd(addrs[i], rv);
                chk("read-only", rv, 24'h000000);
            end
        end
        cvals[5] = 24'($urandom);
        foreach (cvals[i]) begin
            u_host.gap = $urandom_range(0, 3);
            u_host.wr(OFS_EXACT_FREQ_CHANNELS, cvals[i]);
            u_host.rd(OFS_EXACT_FREQ_CHANNELS, rv);
            chk("channel count", rv, cvals[i] & 24'h003FFF);
            chk("exact enable", 24'(o_exact_freq_en), 24'((cvals[i] & 24'h3FFF) >= 2));
        end
        // host outside exact mode must leave the count at zero
        u_host.exact_mode = 1'b0;
        u_host.wr(OFS_EXACT_FREQ_CHANNELS, 24'h000123);
        u_host.rd(OFS_EXACT_FREQ_CHANNELS, rv);
        chk("count outside exact", rv, 24'h000000);
        chk("exact off", 24'(o_exact_freq_en), 24'h000000);
        u_host.exact_mode = 1'b1;
        for (int c = 0; c < 32; c++) begin
            i_gpo_src <= $urandom;
            i_lock_detect <= 1'($urandom);
            i_spi_driver_off <= 1'($urandom);
            w = 24'($urandom) & 24'h0003A0 | 24'(c);
            u_host.wr(OFS_GENERAL_OUTPUT_CONTROL, w);
            u_host.rd(OFS_GENERAL_OUTPUT_CONTROL, rv);
            chk("output control", rv, w);
            settle();
            g = exp_gpo(5'(c), i_gpo_src, w[5]);
            oe = w[7] | !i_spi_driver_off;
            chk("pin", {o_sdo_oe, o_sdo_out, o_sdo_pullup_on, o_sdo_pulldown_on},
                {oe, g, oe & g & !w[8], oe & !g & !w[9]});
            u_host.rd(OFS_OUTPUT_LOCK_STATUS, rv);
            chk("status", rv, {22'h0, i_lock_detect, g});
        end
        for (int k = 0; k < 4; k++) begin
            i_spi_read_active <= k[0];
            i_spi_read_data <= 1'($urandom);
            u_host.wr(OFS_GENERAL_OUTPUT_CONTROL, {17'h0, k[1], 6'h01});
            settle();
            chk("shared out", 24'(o_sdo_out), 24'(k[1] | k[0] ? i_spi_read_data : i_gpo_src[1]));
        end
        i_self_test_running <= 1'b1;
        i_self_test_signature <= 16'($urandom);
        settle();
        u_host.rd(OFS_SELF_TEST_RESULT, rv);
        chk("busy", 24'(rv[BUSY_BIT]), 24'h1);
        i_self_test_running <= 1'b0;
        settle();
        u_host.rd(OFS_SELF_TEST_RESULT, rv);
        chk("signature", rv, 24'(i_self_test_signature));
        report_and_stop();
    end
endmodule // pomx_regs_tb_top
